// file: scp_slave.sv
// two-wire control port slave: link engine on link_clk, registers on clock
//
// Behaviour
// - bytes travel most significant bit first
// - no write acknowledge leaves data released
// - read without master acknowledge ends data
// - first written byte sets base address
// - data bytes write base then incrementing addresses
// - address saturates at the top register
// - no acknowledge for base above top
// - reads start at the pointer: the set base, moved on by any bytes since
// - address advances after each read byte
// - stop condition returns slave to idle
// - repeated start begins a new address phase
// - acknowledge own address on ninth clock
// - eighth bit selects read or write
// - start is data falling, clock high
// - address bit zero from select pin
`timescale 1ns/100ps
`include "scp_map.svh"

module scp_slave
  import scp_pkg::*;
#(
  parameter int NUM_REGS = `SCP_NUM_REGS
) (
  // system clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  // two-wire link, sampled on its own clock
  input  wire logic                  link_clk,
  input  wire logic                  scl,
  input  wire logic                  sda,
  output logic                       sda_data,
  output logic                       sda_en_b,
  // address strap
  input  wire logic                  bus_address_select_pin,
  // register contents
  output logic [NUM_REGS*8-1:0]      ctrl_regs
);

  localparam logic [7:0] TOP = 8'(NUM_REGS - 1);

  generate
    if (NUM_REGS < 2 || NUM_REGS > 32) begin : g_bad_regs
      $error("NUM_REGS must lie between 2 and 32");
    end
  endgenerate

  // lines idle high, so the samplers start high to avoid a false start
  localparam scp_link_s LINK_RST = '{
    scl_m: `SCP_LINE_IDLE, scl_s: `SCP_LINE_IDLE, scl_p: `SCP_LINE_IDLE,
    sda_m: `SCP_LINE_IDLE, sda_s: `SCP_LINE_IDLE, sda_p: `SCP_LINE_IDLE,
    st: SCP_IDLE, en_b: 1'b1, default: '0};

  scp_link_s  l_q;
  scp_link_s  l_d;
  logic       ack_tg;
  logic [7:0] rd_data;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       busy;
  logic       cnt8;
  logic       dev_match;
  logic [7:0] ptr_nx;

  assign scl_rise   = l_q.scl_s && !l_q.scl_p;
  assign scl_fall   = !l_q.scl_s && l_q.scl_p;
  // data moving while the clock is high marks start or stop
  assign start_seen = l_q.scl_s && l_q.scl_p
                      && !l_q.sda_s && l_q.sda_p;
  assign stop_seen  = l_q.scl_s && l_q.scl_p
                      && l_q.sda_s && !l_q.sda_p;
  assign busy       = l_q.req_tg != l_q.ack_s;
  assign cnt8       = l_q.cnt == `SCP_BYTE_BITS;
  assign dev_match  = l_q.sh[7:1]
                      == {`SCP_DEV_ADDR_HI, l_q.sa_s};
  // the pointer sticks at the top register once it gets there
  assign ptr_nx     = (l_q.ptr >= TOP) ? TOP
                      : l_q.ptr + 8'h01;

  always_comb begin
    l_d = l_q;
    l_d.rst_m   = rst_b;
    l_d.rst_s   = l_q.rst_m;
    l_d.scl_m   = scl;
    l_d.scl_s   = l_q.scl_m;
    l_d.scl_p   = l_q.scl_s;
    l_d.sda_m   = sda;
    l_d.sda_s   = l_q.sda_m;
    l_d.sda_p   = l_q.sda_s;
    l_d.sa_m    = bus_address_select_pin;
    l_d.sa_s    = l_q.sa_m;
    l_d.ack_m   = ack_tg;
    l_d.ack_s   = l_q.ack_m;
    l_d.sda_val = 1'b0;
    // read data is only taken once the register side has answered
    if (!busy) begin
      l_d.rdata = rd_data;
    end
    if (stop_seen) begin
      l_d.st    = SCP_IDLE;
      l_d.drive = 1'b0;
    end else if (start_seen) begin
      // a start in any state, repeated or not, opens an address phase
      l_d.st    = SCP_ADDR;
      l_d.cnt   = 4'h0;
      l_d.drive = 1'b0;
    end else begin
      case (l_q.st)
        SCP_IDLE: begin
          l_d.drive = 1'b0;
        end
        SCP_ADDR: begin
          if (scl_rise) begin
            l_d.sh  = {l_q.sh[6:0], l_q.sda_s};
            l_d.cnt = l_q.cnt + 4'h1;
          end else if (scl_fall && cnt8) begin
            if (dev_match) begin
              l_d.drive = 1'b1;
              l_d.rw    = l_q.sh[0];
              l_d.st    = SCP_ACK_A;
              if (l_q.sh[0]) begin
                // fetch the byte at the pointer while the ack bit runs
                l_d.req_tg   = !l_q.req_tg;
                l_d.req_we   = 1'b0;
                l_d.req_addr = l_q.ptr[4:0];
              end
            end else begin
              l_d.st = SCP_IDLE;
            end
          end
        end
        SCP_ACK_A: begin
          if (scl_fall) begin
            l_d.cnt = 4'h0;
            if (l_q.rw) begin
              l_d.st    = SCP_TX;
              l_d.sh    = l_q.rdata;
              l_d.drive = !l_q.rdata[7];
            end else begin
              l_d.st    = SCP_RX;
              l_d.first = 1'b1;
              l_d.drive = 1'b0;
            end
          end
        end
        SCP_RX: begin
          if (scl_rise) begin
            l_d.sh  = {l_q.sh[6:0], l_q.sda_s};
            l_d.cnt = l_q.cnt + 4'h1;
          end else if (scl_fall && cnt8) begin
            if (l_q.first) begin
              if (l_q.sh > TOP) begin
                // line stays released so the master can stop
                l_d.st    = SCP_NAK;
                l_d.drive = 1'b0;
              end else begin
                l_d.ptr   = l_q.sh;
                l_d.first = 1'b0;
                l_d.drive = 1'b1;
                l_d.st    = SCP_ACK_W;
              end
            end else begin
              l_d.req_tg   = !l_q.req_tg;
              l_d.req_we   = 1'b1;
              l_d.req_addr = l_q.ptr[4:0];
              l_d.req_data = l_q.sh;
              l_d.ptr      = ptr_nx;
              l_d.drive    = 1'b1;
              l_d.st       = SCP_ACK_W;
            end
          end
        end
        SCP_ACK_W: begin
          if (scl_fall) begin
            l_d.drive = 1'b0;
            l_d.cnt   = 4'h0;
            l_d.st    = SCP_RX;
          end
        end
        SCP_TX: begin
          if (scl_rise) begin
            l_d.cnt = l_q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt8) begin
              // release for the master's ack and fetch the next byte
              l_d.drive    = 1'b0;
              l_d.st       = SCP_RACK;
              l_d.ptr      = ptr_nx;
              l_d.req_tg   = !l_q.req_tg;
              l_d.req_we   = 1'b0;
              l_d.req_addr = ptr_nx[4:0];
            end else begin
              l_d.sh    = {l_q.sh[6:0], 1'b1};
              l_d.drive = !l_q.sh[6];
            end
          end
        end
        SCP_RACK: begin
          if (scl_rise && l_q.sda_s) begin
            l_d.st = SCP_NAK;
          end else if (scl_fall) begin
            l_d.cnt   = 4'h0;
            l_d.st    = SCP_TX;
            l_d.sh    = l_q.rdata;
            l_d.drive = !l_q.rdata[7];
          end
        end
        SCP_NAK: begin
          l_d.drive = 1'b0;
        end
        default: begin
          l_d.st    = SCP_IDLE;
          l_d.drive = 1'b0;
        end
      endcase
    end
    // enable kept as its own flop so the pin comes straight from a register
    l_d.en_b = !l_d.drive;
  end

  // the reset samplers keep running so the link side can leave reset
  always_ff @(posedge link_clk) begin
    if (!l_q.rst_s) begin
      l_q       <= LINK_RST;
      l_q.rst_m <= l_d.rst_m;
      l_q.rst_s <= l_d.rst_s;
    end else begin
      l_q <= l_d;
    end
  end

  assign sda_data = l_q.sda_val;
  assign sda_en_b = l_q.en_b;

  scp_regfile #(
    .NUM_REGS (NUM_REGS)
  ) u_regfile (
    .clock     (clock),
    .rst_b     (rst_b),
    .req_tg    (l_q.req_tg),
    .req_we    (l_q.req_we),
    .req_addr  (l_q.req_addr),
    .req_data  (l_q.req_data),
    .ack_tg    (ack_tg),
    .rd_data   (rd_data),
    .ctrl_regs (ctrl_regs)
  );

  a_addr_ack: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_ADDR && scl_fall && cnt8 && dev_match)
      |=> (!sda_en_b && l_q.st == SCP_ACK_A))
    else $error("own address not acknowledged");

  a_addr_ignore: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_ADDR && scl_fall && cnt8 && !dev_match)
      |=> (sda_en_b && l_q.st == SCP_IDLE))
    else $error("foreign address acknowledged");

  a_dir_bit: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_ADDR && scl_fall && cnt8 && dev_match)
      |=> l_q.rw == $past(l_q.sh[0]))
    else $error("direction bit not taken from eighth bit");

  a_base_over: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_RX && scl_fall && cnt8 && l_q.first && l_q.sh > TOP)
      |=> (sda_en_b && l_q.st == SCP_NAK))
    else $error("base above top register acknowledged");

  a_base_store: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_RX && scl_fall && cnt8 && l_q.first && l_q.sh <= TOP)
      |=> (l_q.ptr == $past(l_q.sh) && !sda_en_b))
    else $error("base address not stored");

  a_write_step: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_RX && scl_fall && cnt8 && !l_q.first)
      |=> (l_q.req_we && l_q.req_addr == $past(l_q.ptr[4:0])
           && l_q.req_data == $past(l_q.sh) && l_q.ptr == $past(ptr_nx)))
    else $error("write not issued at current address");

  a_ptr_bound: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.ptr == TOP && (l_q.st == SCP_RX || l_q.st == SCP_TX) && scl_fall
      && cnt8 && !l_q.first) |=> l_q.ptr == TOP)
    else $error("address moved past top register");

  a_read_step: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_TX && scl_fall && cnt8)
      |=> (l_q.ptr == $past(ptr_nx) && sda_en_b && l_q.st == SCP_RACK))
    else $error("read address did not advance");

  a_tx_order: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_TX && scl_fall && !cnt8)
      |=> sda_en_b == $past(l_q.sh[6]))
    else $error("read bits not sent top bit first");

  a_ack_release: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_ACK_W && scl_fall)
      |=> (sda_en_b && l_q.st == SCP_RX && l_q.cnt == 4'h0))
    else $error("write ack not released for next byte");

  a_msb_first: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_ACK_A && l_q.rw && scl_fall)
      |=> (sda_en_b == $past(l_q.rdata[7])) ##1 $stable(sda_en_b))
    else $error("first read bit is not the top bit");

  a_end_data: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_RACK && scl_rise && l_q.sda_s)
      |=> (l_q.st == SCP_NAK && sda_en_b))
    else $error("missing master ack did not end data");

  a_nak_quiet: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    (l_q.st == SCP_NAK) |=> sda_en_b)
    else $error("data line pulled after refusal");

  a_stop_idle: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    stop_seen |=> (l_q.st == SCP_IDLE && sda_en_b))
    else $error("stop did not return to idle");

  a_restart: assert property (
    @(posedge link_clk) disable iff (!l_q.rst_s)
    start_seen |=> (l_q.st == SCP_ADDR && l_q.cnt == 4'h0 && sda_en_b))
    else $error("start did not open an address phase");

endmodule

// file: scp_map.svh
// constants of the two-wire control port slave
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// fixed upper six bits of the 7-bit bus address; bit 0 comes from the pin
`define SCP_DEV_ADDR_HI 6'h26

// number of control registers; the highest register address is 1Eh
`define SCP_NUM_REGS 31

// reset value of every control register
`define SCP_REG_RST 8'h00

// data bits per byte on the wire
`define SCP_BYTE_BITS 4'h8

// idle level of the open-drain lines
`define SCP_LINE_IDLE 1'b1

`endif

// file: scp_pkg.sv
// types of the two-wire control port slave
package scp_pkg;

  typedef enum logic [2:0] {
    SCP_IDLE  = 3'b000,
    SCP_ADDR  = 3'b001,
    SCP_ACK_A = 3'b010,
    SCP_RX    = 3'b011,
    SCP_ACK_W = 3'b100,
    SCP_TX    = 3'b101,
    SCP_RACK  = 3'b110,
    SCP_NAK   = 3'b111
  } scp_state_e;

  typedef struct packed {
    logic       rst_m;
    logic       rst_s;
    logic       scl_m;
    logic       scl_s;
    logic       scl_p;
    logic       sda_m;
    logic       sda_s;
    logic       sda_p;
    logic       sa_m;
    logic       sa_s;
    logic       ack_m;
    logic       ack_s;
    scp_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic       first;
    logic [7:0] ptr;
    logic       drive;
    logic       en_b;
    logic       sda_val;
    logic       req_tg;
    logic       req_we;
    logic [4:0] req_addr;
    logic [7:0] req_data;
    logic [7:0] rdata;
  } scp_link_s;

endpackage

// file: scp_regfile.sv
// control register array on the system clock, served by toggle handshake
`timescale 1ns/100ps
`include "scp_map.svh"

module scp_regfile
  import scp_pkg::*;
#(
  parameter int NUM_REGS = `SCP_NUM_REGS
) (
  // system clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  // request from the link domain
  input  wire logic                  req_tg,
  input  wire logic                  req_we,
  input  wire logic [4:0]            req_addr,
  input  wire logic [7:0]            req_data,
  // answer to the link domain
  output logic                       ack_tg,
  output logic [7:0]                 rd_data,
  // register contents
  output logic [NUM_REGS*8-1:0]      ctrl_regs
);

  typedef struct packed {
    logic                     tg_m;
    logic                     tg_s;
    logic                     tg_p;
    logic [7:0]               rdata;
    logic [NUM_REGS-1:0][7:0] mem;
  } scp_rf_s;

  localparam scp_rf_s RF_RST = '{
    tg_m: 1'b0, tg_s: 1'b0, tg_p: 1'b0, rdata: 8'h00,
    mem: {NUM_REGS{`SCP_REG_RST}}};

  scp_rf_s r_q;
  scp_rf_s r_d;
  logic    serve;

  // the request fields are held by the link side until the ack returns
  assign serve = r_q.tg_s != r_q.tg_p;

  always_comb begin
    r_d = r_q;
    r_d.tg_m = req_tg;
    r_d.tg_s = r_q.tg_m;
    if (serve) begin
      r_d.tg_p = r_q.tg_s;
      if (req_we) begin
        r_d.mem[req_addr] = req_data;
      end else begin
        r_d.rdata = r_q.mem[req_addr];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_q <= RF_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign ack_tg    = r_q.tg_p;
  assign rd_data   = r_q.rdata;
  assign ctrl_regs = r_q.mem;

  a_write_store: assert property (
    @(posedge clock) disable iff (!rst_b)
    (serve && req_we) |=> r_q.mem[$past(req_addr)] == $past(req_data))
    else $error("written byte not stored at its address");

  a_read_fetch: assert property (
    @(posedge clock) disable iff (!rst_b)
    (serve && !req_we) |=> (r_q.rdata == $past(r_q.mem[req_addr])
      && ack_tg == $past(r_q.tg_s)))
    else $error("read data or ack toggle wrong");

endmodule

// file: scp_bus_master.sv
// two-wire bus master model for the far side of the control port
`timescale 1ns/100ps

module scp_bus_master #(
  parameter int HALF = 20
) (
  // timing reference
  input  wire logic clock,
  // bus lines, master side
  output logic      scl,
  output logic      sda_o,
  input  wire logic sda
);
  initial begin
    scl   = 1'b1;
    sda_o = 1'b1;
  end

  // phases of 2 us keep clear of the slave's 1.5 us minimum
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask

  // also serves as repeated start when entered mid-transfer
  task automatic start();
    sda_o = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_o = 1'b0;
    wt(HALF);
    scl = 1'b0;
    wt(5);
  endtask

  task automatic stop();
    sda_o = 1'b0;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    sda_o = 1'b1;
    wt(HALF);
  endtask

  // data only moves once scl has been low a while, never near its edge
  task automatic bit_out(input logic b);
    sda_o = b;
    wt(HALF);
    scl = 1'b1;
    wt(HALF);
    scl = 1'b0;
    wt(5);
  endtask

  task automatic bit_in(output logic b);
    sda_o = 1'b1;
    wt(HALF);
    scl = 1'b1;
    wt(HALF / 2);
    b = sda;
    wt(HALF - HALF / 2);
    scl = 1'b0;
    wt(5);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(a);
    ack = ~a;
  endtask

  // last byte of a read is answered with no acknowledge
  task automatic recv_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(~ack);
    sda_o = 1'b1;
  endtask
endmodule

// file: scp_slave_test.sv
// self-checking bench of the two-wire control port slave
`timescale 1ns/100ps
`include "scp_map.svh"

module scp_slave_test;
  import scp_pkg::*;
  localparam int NREG  = 31;
  localparam int LIMIT = 30000;

  logic              clock;
  logic              rst_b;
  logic              link_clk;
  logic              sel_pin;
  logic              scl;
  logic              sda_m;
  wire logic         sda;
  logic              sda_data;
  logic              sda_en_b;
  logic [NREG*8-1:0] ctrl_regs;
  logic              a;
  logic [7:0]        d;
  int                miscompares;
  int                comparisons;
  int                cycles;

  // pulled-up wire: low while either party pulls it
  assign sda = sda_m & (sda_en_b | sda_data);

  scp_slave #(.NUM_REGS(NREG)) dut (
    .clock                  (clock),
    .rst_b                  (rst_b),
    .link_clk               (link_clk),
    .scl                    (scl),
    .sda                    (sda),
    .sda_data               (sda_data),
    .sda_en_b               (sda_en_b),
    .bus_address_select_pin (sel_pin),
    .ctrl_regs              (ctrl_regs)
  );

  scp_bus_master u_m (
    .clock (clock),
    .scl   (scl),
    .sda_o (sda_m),
    .sda   (sda)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    chk8({7'h00, e}, {7'h00, g});
  endtask

  function automatic logic [7:0] reg_at(input int n);
    return ctrl_regs[8*n +: 8];
  endfunction

  function automatic logic [7:0] adr(input logic p, input logic rw);
    return {`SCP_DEV_ADDR_HI, p, rw};
  endfunction

  task automatic set_base(input logic [7:0] b, output logic ok);
    u_m.start();
    u_m.send_byte(adr(sel_pin, 1'b0), a);
    chk1(1'b1, a);
    u_m.send_byte(b, ok);
  endtask

  task automatic t_reset();
    chk1(1'b1, sda_en_b);
    for (int n = 0; n < NREG; n++) begin
      chk8(`SCP_REG_RST, reg_at(n));
    end
  endtask

  // only the address matching the select pin is answered
  task automatic t_address(input logic p);
    @(negedge clock);
    sel_pin = p;
    u_m.wt(20);
    u_m.start();
    u_m.send_byte(adr(~p, 1'b0), a);
    chk1(1'b0, a);
    u_m.start();
    u_m.send_byte(adr(p, 1'b0), a);
    chk1(1'b1, a);
    u_m.stop();
    u_m.send_byte(adr(p, 1'b0), a);
    chk1(1'b0, a);
    u_m.stop();
  endtask

  // reset in mid transfer clears the registers and frees the line
  task automatic t_mid_reset();
    set_base(8'h05, a);
    chk1(1'b1, a);
    u_m.send_byte(8'hA5, a);
    chk1(1'b1, a);
    u_m.stop();
    u_m.wt(20);
    chk8(8'hA5, reg_at(5));
    u_m.start();
    u_m.send_byte(adr(sel_pin, 1'b0), a);
    chk1(1'b1, a);
    @(negedge clock);
    rst_b = 1'b0;
    repeat (12) @(negedge clock);
    chk1(1'b1, sda_en_b);
    chk8(`SCP_REG_RST, reg_at(5));
    rst_b = 1'b1;
    u_m.wt(20);
    u_m.stop();
    set_base(8'h05, a);
    chk1(1'b1, a);
    u_m.send_byte(8'h3C, a);
    chk1(1'b1, a);
    u_m.stop();
    u_m.wt(20);
    chk8(8'h3C, reg_at(5));
  endtask

  // four bytes from 1Ch: the last two both land in 1Eh
  task automatic t_write_top();
    logic [7:0] v[4] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3};
    set_base(8'h1C, a);
    chk1(1'b1, a);
    for (int i = 0; i < 4; i++) begin
      u_m.send_byte(v[i], a);
      chk1(1'b1, a);
    end
    u_m.stop();
    u_m.wt(20);
    chk8(8'hA5, reg_at(28));
    chk8(8'h3C, reg_at(29));
    chk8(8'hC3, reg_at(30));
    chk8(8'h00, reg_at(27));
  endtask

  task automatic t_bad_base();
    set_base(8'h1F, a);
    chk1(1'b0, a);
    chk1(1'b1, sda_en_b);
    u_m.send_byte(8'h77, a);
    chk1(1'b0, a);
    u_m.stop();
    u_m.wt(20);
    chk8(8'hC3, reg_at(30));
  endtask

  task automatic t_read(input logic [7:0] b, input logic [7:0] e0,
                        input logic [7:0] e1, input logic [7:0] e2);
    set_base(b, a);
    chk1(1'b1, a);
    u_m.start();
    u_m.send_byte(adr(sel_pin, 1'b1), a);
    chk1(1'b1, a);
    u_m.recv_byte(d, 1'b1);
    chk8(e0, d);
    u_m.recv_byte(d, 1'b1);
    chk8(e1, d);
    u_m.recv_byte(d, 1'b0);
    chk8(e2, d);
    u_m.wt(10);
    chk1(1'b1, sda_en_b);
    u_m.wt(10);
    chk1(1'b1, sda);
    u_m.stop();
  endtask

  initial begin
    rst_b       = 1'b0;
    sel_pin     = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    u_m.wt(20);
    t_reset();
    t_address(1'b1);
    t_mid_reset();
    t_write_top();
    t_bad_base();
    t_read(8'h1C, 8'hA5, 8'h3C, 8'hC3);
    t_address(1'b0);
    t_read(8'h1E, 8'hC3, 8'hC3, 8'hC3);
    end_sim();
  end
endmodule
